// file: power_unit_pkg.sv
// Constants and types shared by the power mode and wake-up control block.
package power_unit_pkg;

  // Register indices; the byte address is four times the index, offset by PAGE_F_BASE for the mode options register.
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_WAKE_CFG = 8'hb5;
  localparam logic [7:0] IDX_MODE_OPTIONS = 8'hb5;
  localparam logic [7:0] IDX_POWER_STATUS = 8'hc0;
  // The two registers sharing index 8'hb5 sit on separate pages.
  localparam logic [31:0] PAGE_F_BASE = 32'h0000_0400;
  localparam logic [31:0] ADDR_POWER_CONTROL = {22'h0, IDX_POWER_CONTROL, 2'b00};
  localparam logic [31:0] ADDR_WAKE_CFG = {22'h0, IDX_WAKE_CFG, 2'b00};
  localparam logic [31:0] ADDR_MODE_OPTIONS = PAGE_F_BASE | {22'h0, IDX_MODE_OPTIONS, 2'b00};
  localparam logic [31:0] ADDR_POWER_STATUS = {22'h0, IDX_POWER_STATUS, 2'b00};

  // Wake configuration fields.
  localparam int CFG_SLEEP = 7;
  localparam int CFG_SUSPEND = 6;
  localparam int CFG_CLEAR = 5;
  localparam int CFG_RESET_PIN_FLAG = 4;
  localparam int CFG_CLOCK_FAIL = 3;
  localparam int CFG_CLOCK_ALARM = 2;
  localparam int CFG_PORT_MATCH = 1;
  localparam int CFG_COMPARATOR = 0;

  // Mode option fields.
  localparam int MODE_LF_CLOCK_OUT = 7;
  localparam int MODE_WAKE_OUT = 6;
  localparam int MODE_MONITOR_DISABLE = 5;

  // Power control fields.
  localparam int CTRL_GP_LSB = 2;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_IDLE = 0;

  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_OPTIONS_RESET = 8'h00;
  localparam logic [4:0] WAKE_FLAGS_RESET = 5'h00;
  localparam logic [3:0] WAKE_ENABLES_RESET = 4'h0;

  // Clocks during which flags read zero after leaving suspend.
  localparam logic [1:0] FLAG_BLANK_CYCLES = 2'd2;

  typedef enum logic [2:0] {
    PWR_ACTIVE = 3'b000,
    PWR_IDLE = 3'b001,
    PWR_STOP = 3'b011,
    PWR_SUSPEND = 3'b010,
    PWR_SLEEP = 3'b110
  } power_state_e;

endpackage

// file: power_mode_wakeup_control.sv
// Power mode selection, wake-up sources and supply monitor control.
`timescale 1ns/1ps
`default_nettype none

module power_mode_wakeup_control
  import power_unit_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [31:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic clock_fail_event,
  input wire logic clock_alarm_event,
  input wire logic port_match_event,
  input wire logic comparator_out,
  input wire logic reset_pin_n,
  input wire logic reset_source_event,
  input wire logic interrupt_pending,
  input wire logic lf_clock,
  output power_unit_pkg::power_state_e power_mode,
  output logic lp_osc_keep_on,
  output logic lf_clock_out,
  output logic lf_clock_out_en,
  output logic wake_request_out,
  output logic wake_request_out_en,
  output logic supply_monitor_disable,
  output logic por_request
);
  import power_unit_pkg::*;

  typedef struct packed {
    power_state_e state;
    logic ack;
    logic [31:0] rdata;
    logic [5:0] general_purpose_flags;
    logic lf_out_enable;
    logic wake_out_enable;
    logic monitor_disable;
    logic [3:0] enables;
    logic [4:0] flags;
    logic [1:0] blank;
    logic comparator_prev;
    logic reset_pin_prev;
    logic lf_out;
    logic wake_out;
    logic por;
    logic osc_keep;
  } pmu_s;

  pmu_s st;
  pmu_s next_st;
  logic access;
  logic write_ok;
  logic wr_cfg;
  logic wr_ctrl;
  logic wr_mode;
  logic [4:0] events;
  logic wake_hit;

  // The bus answers one cycle after the request; writes land on the ack edge.
  assign access = cyc_i && stb_i;
  assign write_ok = access && we_i && st.ack && sel_i[0];
  assign wr_cfg = write_ok && (adr_i == ADDR_WAKE_CFG);
  assign wr_ctrl = write_ok && (adr_i == ADDR_POWER_CONTROL);
  assign wr_mode = write_ok && (adr_i == ADDR_MODE_OPTIONS);

  // Event order matches the flag field order: pin, fail, alarm, match, comparator.
  assign events = {st.reset_pin_prev && !reset_pin_n, clock_fail_event,
                   clock_alarm_event, port_match_event,
                   comparator_out && !st.comparator_prev};
  assign wake_hit = events[4] || |(events[3:0] & st.enables);

  always_comb
  begin
    next_st = st;
    next_st.ack = 1'b0;
    next_st.por = 1'b0;
    next_st.comparator_prev = comparator_out;
    next_st.reset_pin_prev = reset_pin_n;
    if (st.blank != 2'd0)
    begin
      next_st.blank = st.blank - 2'd1;
    end

    // A new event beats a clear in the same cycle.
    if (wr_cfg && dat_i[CFG_CLEAR])
    begin
      next_st.flags = events;
    end
    else
    begin
      next_st.flags = st.flags | events;
    end

    if (wr_cfg)
    begin
      next_st.enables = dat_i[3:0];
      // Refusal looks at the flags held before this write.
      if (st.state == PWR_ACTIVE && st.flags == 5'h00)
      begin
        if (dat_i[CFG_SLEEP])
        begin
          next_st.state = PWR_SLEEP;
        end
        else if (dat_i[CFG_SUSPEND])
        begin
          next_st.state = PWR_SUSPEND;
        end
      end
    end

    if (wr_ctrl)
    begin
      next_st.general_purpose_flags = dat_i[7:CTRL_GP_LSB];
      if (st.state == PWR_ACTIVE)
      begin
        if (dat_i[CTRL_STOP])
        begin
          next_st.state = PWR_STOP;
        end
        else if (dat_i[CTRL_IDLE])
        begin
          next_st.state = PWR_IDLE;
        end
      end
    end

    if (wr_mode)
    begin
      next_st.lf_out_enable = dat_i[MODE_LF_CLOCK_OUT];
      next_st.wake_out_enable = dat_i[MODE_WAKE_OUT];
      next_st.monitor_disable = dat_i[MODE_MONITOR_DISABLE];
      if (st.monitor_disable && !dat_i[MODE_MONITOR_DISABLE])
      begin
        next_st.por = 1'b1;
      end
    end

    // Any reset source with the monitor off escalates and re-arms the monitor.
    if (reset_source_event && st.monitor_disable)
    begin
      next_st.por = 1'b1;
      next_st.monitor_disable = 1'b0;
    end

    case (st.state)
      PWR_ACTIVE:
      begin
        // Entries decoded above must survive; nothing else moves the state here.
      end
      PWR_IDLE:
      begin
        if (interrupt_pending)
        begin
          next_st.state = PWR_ACTIVE;
        end
      end
      PWR_STOP:
      begin
        if (reset_source_event)
        begin
          next_st.state = PWR_ACTIVE;
        end
      end
      PWR_SUSPEND:
      begin
        if (wake_hit)
        begin
          next_st.state = PWR_ACTIVE;
          next_st.blank = FLAG_BLANK_CYCLES;
          next_st.enables = WAKE_ENABLES_RESET;
        end
      end
      PWR_SLEEP:
      begin
        if (wake_hit)
        begin
          next_st.state = PWR_ACTIVE;
          next_st.enables = WAKE_ENABLES_RESET;
        end
      end
      default:
      begin
        next_st.state = PWR_ACTIVE;
      end
    endcase

    if (access && !st.ack)
    begin
      next_st.ack = 1'b1;
      if (adr_i == ADDR_WAKE_CFG)
      begin
        // Flags are hidden while they settle after a suspend wake.
        next_st.rdata = {27'h0, (st.blank != 2'd0) ? 5'h00 : st.flags};
      end
      else if (adr_i == ADDR_MODE_OPTIONS)
      begin
        next_st.rdata = {24'h0, st.lf_out_enable, st.wake_out_enable,
                         st.monitor_disable, 5'b00000};
      end
      else if (adr_i == ADDR_POWER_CONTROL)
      begin
        next_st.rdata = {24'h0, st.general_purpose_flags, 2'b00};
      end
      else if (adr_i == ADDR_POWER_STATUS)
      begin
        next_st.rdata = {29'h0, st.state};
      end
      else
      begin
        next_st.rdata = 32'h0;
      end
    end

    next_st.lf_out = lf_clock && next_st.lf_out_enable;
    next_st.wake_out = next_st.wake_out_enable && (next_st.state != PWR_SLEEP);
    // The slow internal oscillator stays up while anything is flagged.
    next_st.osc_keep = |next_st.flags;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{state: PWR_ACTIVE, ack: 1'b0, rdata: 32'h0,
              general_purpose_flags: POWER_CONTROL_RESET[7:2],
              lf_out_enable: MODE_OPTIONS_RESET[MODE_LF_CLOCK_OUT],
              wake_out_enable: MODE_OPTIONS_RESET[MODE_WAKE_OUT],
              monitor_disable: MODE_OPTIONS_RESET[MODE_MONITOR_DISABLE],
              enables: WAKE_ENABLES_RESET, flags: WAKE_FLAGS_RESET, blank: 2'd0,
              comparator_prev: 1'b0, reset_pin_prev: 1'b1, lf_out: 1'b0,
              wake_out: 1'b0, por: 1'b0, osc_keep: 1'b0};
    end
    else
    begin
      st <= next_st;
    end
  end

  assign dat_o = st.rdata;
  assign ack_o = st.ack;
  assign power_mode = st.state;
  assign lp_osc_keep_on = st.osc_keep;
  assign lf_clock_out = st.lf_out;
  assign lf_clock_out_en = st.lf_out_enable;
  assign wake_request_out = st.wake_out;
  assign wake_request_out_en = st.wake_out_enable;
  assign supply_monitor_disable = st.monitor_disable;
  assign por_request = st.por;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_sleep_entry_ok: assert property (wr_cfg && dat_i[CFG_SLEEP] && st.state == PWR_ACTIVE && st.flags == 5'h00 |=> power_mode == PWR_SLEEP) else $error("sleep not entered");
  a_suspend_entry_ok: assert property (wr_cfg && !dat_i[CFG_SLEEP] && dat_i[CFG_SUSPEND] && st.state == PWR_ACTIVE && st.flags == 5'h00 |=> power_mode == PWR_SUSPEND) else $error("suspend not entered");
  a_flag_clear_all: assert property (wr_cfg && dat_i[CFG_CLEAR] && events == 5'h00 |=> st.flags == 5'h00 && !lp_osc_keep_on) else $error("flags not cleared");
  a_pin_edge_flag: assert property ($fell(reset_pin_n) |=> st.flags[CFG_RESET_PIN_FLAG]) else $error("reset pin flag missing");
  a_flagged_refuse: assert property (wr_cfg && (dat_i[CFG_SLEEP] || dat_i[CFG_SUSPEND]) && st.flags != 5'h00 && st.state == PWR_ACTIVE |=> power_mode == PWR_ACTIVE) else $error("entry despite flags");
  a_blank_read_zero: assert property (access && !st.ack && !we_i && adr_i == ADDR_WAKE_CFG && st.blank != 2'd0 |=> ack_o && dat_o[4:0] == 5'h00) else $error("flags visible during settle");
  a_suspend_blank_two: assert property (power_mode == PWR_SUSPEND && wake_hit |=> power_mode == PWR_ACTIVE ##1 st.blank == 2'd1 ##1 st.blank == 2'd0) else $error("settle window wrong");
  a_monitor_por_pulse: assert property (wr_mode && supply_monitor_disable && !dat_i[MODE_MONITOR_DISABLE] |=> por_request ##1 !por_request) else $error("monitor por missing");
  a_reset_rearm: assert property (reset_source_event && supply_monitor_disable |=> por_request && !supply_monitor_disable) else $error("monitor not rearmed");
  a_wake_low_asleep: assert property (wake_request_out_en && power_mode == PWR_SLEEP |-> !wake_request_out) else $error("wake request high asleep");
  a_pin_wakes_sleep: assert property (power_mode == PWR_SLEEP && $fell(reset_pin_n) |=> power_mode == PWR_ACTIVE) else $error("pin edge did not wake");
  a_gp_flags_store: assert property (wr_ctrl |=> dat_o[1:0] == 2'b00 && st.general_purpose_flags == $past(dat_i[7:2])) else $error("general flags not stored");
  a_ack_single: assert property (ack_o |=> !ack_o) else $error("ack held too long");

  c_sleep_and_wake: cover property (power_mode == PWR_SLEEP ##[1:50] power_mode == PWR_ACTIVE);
  c_suspend_refused: cover property (wr_cfg && dat_i[CFG_SUSPEND] && st.flags != 5'h00);
  c_monitor_por: cover property (por_request);
  c_idle_cycle: cover property (power_mode == PWR_IDLE ##[1:20] power_mode == PWR_ACTIVE);

endmodule

`default_nettype wire

// file: tb_power_mode_wakeup_control.sv
// Self-checking bench for the power mode and wake-up control block.
`timescale 1ns/1ps
`default_nettype none

module tb_power_mode_wakeup_control;
  import power_unit_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [31:0] adr_i = 32'h0, dat_i = 32'h0;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_o;
  logic ack_o;
  logic clock_fail_event = 1'b0, clock_alarm_event = 1'b0, port_match_event = 1'b0;
  logic comparator_out = 1'b0, reset_pin_n = 1'b1, reset_source_event = 1'b0;
  logic interrupt_pending = 1'b0, lf_clock = 1'b0, lf_prev = 1'b0;
  power_state_e power_mode;
  logic lp_osc_keep_on, lf_clock_out, lf_clock_out_en, wake_request_out;
  logic wake_request_out_en, supply_monitor_disable, por_request;
  int err_total = 0, comparisons = 0, cycles = 0, por_cnt = 0, base;
  logic [3:0] lf_div = 4'h0;
  logic [7:0] q, r;

  power_mode_wakeup_control dut_u (.clk_sys(clk_sys), .rstn(rstn), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .clock_fail_event(clock_fail_event), .clock_alarm_event(clock_alarm_event),
    .port_match_event(port_match_event), .comparator_out(comparator_out),
    .reset_pin_n(reset_pin_n), .reset_source_event(reset_source_event),
    .interrupt_pending(interrupt_pending), .lf_clock(lf_clock), .power_mode(power_mode),
    .lp_osc_keep_on(lp_osc_keep_on), .lf_clock_out(lf_clock_out),
    .lf_clock_out_en(lf_clock_out_en), .wake_request_out(wake_request_out),
    .wake_request_out_en(wake_request_out_en),
    .supply_monitor_disable(supply_monitor_disable), .por_request(por_request));

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  // The slow clock is a divided copy; lf_prev is what a one-cycle register would show.
  always @(posedge clk_sys)
  begin
    lf_div <= lf_div + 4'h1;
    lf_clock <= lf_div[2];
    lf_prev <= lf_clock;
    if (por_request === 1'b1) por_cnt <= por_cnt + 1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total = err_total + 1;
      test_done();
    end
  end

  function automatic logic [7:0] exp_mode(input logic [7:0] d);
    return d & 8'he0;
  endfunction

  function automatic logic [7:0] exp_ctrl(input logic [7:0] d);
    return d & 8'hfc;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wb(input logic [31:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] rd);
    @(posedge clk_sys);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= {24'h0, d};
    sel_i <= 4'h1;
    // Look at ack between edges so the launching edge is never raced.
    do @(negedge clk_sys); while (ack_o !== 1'b1);
    rd = dat_o[7:0];
    @(posedge clk_sys);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp)
    begin
      err_total = err_total + 1;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  // Index matches the flag bit: 0 comparator, 1 match, 2 alarm, 3 fail, 4 pin.
  task automatic ev(input int i);
    @(posedge clk_sys);
    case (i)
      0: comparator_out <= 1'b1;
      1: port_match_event <= 1'b1;
      2: clock_alarm_event <= 1'b1;
      3: clock_fail_event <= 1'b1;
      default: reset_pin_n <= 1'b0;
    endcase
    @(posedge clk_sys);
    comparator_out <= 1'b0;
    port_match_event <= 1'b0;
    clock_alarm_event <= 1'b0;
    clock_fail_event <= 1'b0;
    reset_pin_n <= 1'b1;
    tick(2);
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    void'($urandom(94));
    tick(8);
    rstn <= 1'b1;
    tick(1);
    chk(power_mode, PWR_ACTIVE);
    wb(ADDR_POWER_CONTROL, 1'b0, 8'h0, q); chk(q, 8'h00);
    wb(ADDR_MODE_OPTIONS, 1'b0, 8'h0, q); chk(q, 8'h00);
    wb(32'h0000_0010, 1'b0, 8'h0, q); chk(q, 8'h00);
    repeat (3)
    begin
      r = 8'($urandom);
      wb(ADDR_POWER_CONTROL, 1'b1, r & 8'hfc, q);
      wb(ADDR_POWER_CONTROL, 1'b0, 8'h0, q); chk(q, exp_ctrl(r));
    end
    wb(ADDR_POWER_CONTROL, 1'b1, 8'h02, q); tick(1); chk(power_mode, PWR_STOP);
    wb(ADDR_POWER_CONTROL, 1'b0, 8'h0, q); chk(q, 8'h00);
    reset_source_event <= 1'b1; tick(1); reset_source_event <= 1'b0; tick(2);
    chk(power_mode, PWR_ACTIVE);
    wb(ADDR_POWER_CONTROL, 1'b1, 8'h01, q); tick(1); chk(power_mode, PWR_IDLE);
    interrupt_pending <= 1'b1; tick(1); interrupt_pending <= 1'b0; tick(2);
    chk(power_mode, PWR_ACTIVE);
    for (int k = 0; k < 2; k++)
    begin
      r = 8'($urandom);
      r[7] = k[0];
      r[5] = 1'b0;
      wb(ADDR_MODE_OPTIONS, 1'b1, r, q); tick(2);
      wb(ADDR_MODE_OPTIONS, 1'b0, 8'h0, q); chk(q, exp_mode(r));
      chk(lf_clock_out_en, r[7]);
      chk(wake_request_out_en, r[6]);
      for (int n = 0; n < 12; n++)
      begin
        tick(1); chk(lf_clock_out, lf_prev & r[7]);
      end
    end
    for (int k = 0; k < 4; k++)
    begin
      r = (k == 0) ? 8'h1f : (8'($urandom) & 8'h1f);
      wb(ADDR_WAKE_CFG, 1'b1, 8'h20, q);
      for (int i = 0; i < 5; i++) if (r[i]) ev(i);
      wb(ADDR_WAKE_CFG, 1'b0, 8'h0, q); chk(q[4:0], r[4:0]);
      chk(lp_osc_keep_on, |r[4:0]);
      wb(ADDR_WAKE_CFG, 1'b1, 8'h80, q); tick(1);
      chk(power_mode, (|r[4:0]) ? PWR_ACTIVE : PWR_SLEEP);
      if (power_mode === PWR_SLEEP) ev(4);
    end
    wb(ADDR_WAKE_CFG, 1'b1, 8'h20, q);
    wb(ADDR_WAKE_CFG, 1'b0, 8'h0, q); chk(q[4:0], 5'h00);
    wb(ADDR_MODE_OPTIONS, 1'b1, 8'h40, q);
    for (int i = 0; i < 4; i++)
    begin
      wb(ADDR_WAKE_CFG, 1'b1, 8'h20, q);
      wb(ADDR_WAKE_CFG, 1'b1, (i[0] ? 8'h40 : 8'h80) | (8'h01 << i), q); tick(1);
      chk(power_mode, i[0] ? PWR_SUSPEND : PWR_SLEEP);
      if (!i[0]) chk(wake_request_out, 1'b0);
      ev((i + 1) % 4); chk(power_mode, i[0] ? PWR_SUSPEND : PWR_SLEEP);
      ev(i); chk(power_mode, PWR_ACTIVE);
      chk(wake_request_out, 1'b1);
      wb(ADDR_WAKE_CFG, 1'b0, 8'h0, q);
      chk(q[i], 1'b1);
    end
    wb(ADDR_WAKE_CFG, 1'b1, 8'h20, q);
    wb(ADDR_WAKE_CFG, 1'b1, 8'h80, q); tick(1);
    ev(4); chk(power_mode, PWR_ACTIVE);
    base = por_cnt;
    wb(ADDR_MODE_OPTIONS, 1'b1, 8'h20, q); tick(2);
    chk(supply_monitor_disable, 1'b1);
    wb(ADDR_MODE_OPTIONS, 1'b1, 8'h00, q); tick(3);
    chk(por_cnt - base, 1);
    wb(ADDR_MODE_OPTIONS, 1'b1, 8'h20, q); tick(2);
    reset_source_event <= 1'b1; tick(1); reset_source_event <= 1'b0; tick(3);
    chk(por_cnt - base, 2);
    chk(supply_monitor_disable, 1'b0);
    test_done();
  end
endmodule

`default_nettype wire
